// [tla_alert_checker.sv]
// port assertions of the temperature limit and alert logic
// assumes one clock and one-cycle strobes from the link layer and converter
`timescale 1ns/1ps
module tla_alert_checker (
   input wire logic                      i_clk,
   input wire logic                      i_rstn,
   input wire logic                      i_conv_done,
   input wire logic [13:0]               i_conv_code,
   input wire logic                      i_cfg_rd,
   input wire logic                      i_cmd_valid,
   input wire logic [7:0]                i_cmd_byte,
   input wire logic [15:0]               o_temp_word,
   input wire logic [15:0]               o_cfg_ctrl,
   input wire logic                      o_cfg_rvalid,
   input wire tla_pkg::tla_flags_t [1:0] o_flags,
   input wire logic [1:0]                o_limit_output_n_o,
   input wire logic [1:0]                o_limit_output_n_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // no conversion may land while a clear settles, or it could re-trip
   sequence quiet; !i_conv_done [*3]; endsequence
   sequence clr1; i_cmd_valid && i_cmd_byte == tla_pkg::CMD_ALERT_CLR1 && !o_cfg_ctrl[10] && !i_conv_done; endsequence
   od_never_high_a: assert property (o_limit_output_n_o == 2'b00) else $error("pin data high");
   temp_word_a: assert property (i_conv_done ##1 quiet |-> o_temp_word == {$past(i_conv_code, 3), 2'b00})
      else $error("temp word");
   rd_answer_a: assert property (i_cfg_rd |-> ##[1:3] o_cfg_rvalid) else $error("no read answer");
   rd_clear_a: assert property (i_cfg_rd && !o_cfg_ctrl[10] && !i_conv_done ##1 quiet |-> o_flags[0] == 2'b00)
      else $error("flags kept");
   clr_release_a: assert property (clr1 ##1 quiet |-> o_limit_output_n_oe[0] == o_cfg_ctrl[7])
      else $error("pin kept");
   therm_low_a: assert property (o_cfg_ctrl[9] && $past(o_cfg_ctrl[9], 2) |-> !o_flags[1].low_excursion_flag)
      else $error("low flag set");
   therm_hold_a: assert property ($changed(o_flags[1]) && o_cfg_ctrl[9] && $past(o_cfg_ctrl[9], 3)
      |-> $past(i_conv_done) || $past(i_conv_done, 2) || $past(i_conv_done, 3)) else $error("flag moved");
   therm_pin_a: assert property ((o_cfg_ctrl[9] && $stable(o_flags[1]) && $stable(o_cfg_ctrl)) [*4]
      |-> o_limit_output_n_oe[1] == (o_flags[1].high_excursion_flag ^ o_cfg_ctrl[3])) else $error("pin level");
endmodule : tla_alert_checker
bind tla_alert_top tla_alert_checker u_tla_alert_checker (.i_clk, .i_rstn, .i_conv_done, .i_conv_code, .i_cfg_rd,
   .i_cmd_valid, .i_cmd_byte, .o_temp_word, .o_cfg_ctrl, .o_cfg_rvalid, .o_flags, .o_limit_output_n_o,
   .o_limit_output_n_oe);

// [tla_alert_top.sv]
// temperature result register, limit registers, configuration and two alert channels
// assumes the link layer, the conversion engine and the nonvolatile store share i_clk
// and present one-cycle strobes; no synchroniser is needed on those inputs
//
// What this block does
// - keep each 14-bit result in temperature register
// - result is twos complement, 1/64 degree steps
// - code sits left-justified in every word
// - two channels, each with writable limit pair
// - compare every new result against both limits
// - mode bit: 0 latched window, 1 threshold
// - window mode latches flags and asserts output
// - window output released by clear or read
// - window flags cleared by configuration read
// - threshold: set above high, release below low
// - threshold mode low flag reads zero
// - threshold state changes only at conversions
// - limits load from nonvolatile store at reset
// - disabled output still follows its polarity bit
// - polarity bit sets output active level
// - outputs are open-drain, never drive high
`timescale 1ns/1ps
module tla_alert_top (
   input  wire logic                    i_clk,         // device clock, 125 mhz
   input  wire logic                    i_rstn,        // async reset, active low
   // conversion engine
   input  wire logic                    i_conv_done,   // result valid, one cycle
   input  wire logic [13:0]             i_conv_code,   // raw 14-bit twos complement code
   // nonvolatile limit defaults
   input  wire tla_pkg::tla_lim_t [1:0] i_nvm_lim,     // stored defaults, index 0 = channel one
   input  wire logic                    i_nvm_valid,   // store output is settled
   input  wire logic                    i_soft_reset,  // global software reset, one cycle
   // link layer requests
   input  wire logic                    i_wr_en,       // register write strobe
   input  wire tla_pkg::tla_sel_t       i_wr_sel,      // register being written
   input  wire logic [15:0]             i_wr_data,     // word, already paired lsb first
   input  wire logic                    i_cfg_rd,      // configuration read strobe
   input  wire logic                    i_cmd_valid,   // command byte strobe
   input  wire logic [7:0]              i_cmd_byte,    // command byte
   // register contents
   output logic [15:0]                  o_temp_word,   // temperature register
   output tla_pkg::tla_lim_t [1:0]      o_lim,         // limit registers
   output logic [15:0]                  o_cfg_ctrl,    // writable configuration bits
   output logic [15:0]                  o_cfg_rdata,   // configuration word captured by a read
   output logic                         o_cfg_rvalid,  // o_cfg_rdata is fresh, one cycle
   output tla_pkg::tla_flags_t [1:0]    o_flags,       // live excursion flags
   output logic                         o_lim_loaded,  // limits hold a loaded or written value
   // open-drain alert pins, limit_output_one is index 0
   output logic [1:0]                   o_limit_output_n_o,   // pin data, always low
   output logic [1:0]                   o_limit_output_n_oe   // high while pulling low
);

   // load sequencer: waits for the store after every reset
   typedef enum logic {
      LD_PEND,
      LD_DONE
   } tla_ld_t;

   tla_ld_t                 ld_reg;         // load sequencer state
   tla_ld_t                 ld_next;
   logic [15:0]             temp_reg;       // temperature register
   logic [15:0]             cfg_reg;        // writable configuration bits
   logic [15:0]             cfg_next;
   logic [15:0]             rdata_reg;      // configuration read capture
   logic                    rvalid_reg;     // read capture strobe
   tla_pkg::tla_lim_t [1:0] lim_reg;        // limit registers, index 0 = channel one
   tla_pkg::tla_lim_t [1:0] lim_next;
   logic                    loaded_reg;     // limits hold a loaded or written value
   logic                    loaded_next;
   logic [15:0]             temp_next;      // next temperature register value
   logic [15:0]             rdata_next;     // next read capture value
   logic [15:0]             rd_word;        // configuration word as a read would see it now

   // alert channel count, fixed by the two alert pins
   localparam int unsigned  N_CH = 2;

   // decoded requests and per-channel controls
   wire  logic [15:0]       conv_word;      // new result, left-justified
   wire  logic [15:0]       wr_word;        // written limit, pad bits forced to zero
   wire  logic [15:0]       cfg_wr_word;    // written configuration, writable bits only
   wire  logic              wr_cfg;         // configuration write this cycle
   wire  logic [1:0]        wr_high;        // high limit write, per channel
   wire  logic [1:0]        wr_low;         // low limit write, per channel
   wire  logic [1:0]        alert_clr;      // global alert clear, per channel
   wire  logic [1:0]        therm_mode;     // latch or threshold select, per channel
   wire  logic [1:0]        polarity;       // output active level, per channel

   // channel results, each straight from a flop inside the channel
   tla_pkg::tla_flags_t [1:0] ch_flags;     // excursion flag flops
   logic [1:0]              pin_o;          // pin data flops
   logic [1:0]              pin_oe;         // pin pull-down enable flops

   // left-justify, zero pad bits
   // the pad bits are forced to zero so that compares never see stale low bits
   assign conv_word   = {i_conv_code, {tla_pkg::PAD_W{1'b0}}};

   // host limits left-justified too
   // a host that writes nonzero pad bits gets them dropped, not stored
   assign wr_word     = {i_wr_data[tla_pkg::WORD_W-1:tla_pkg::PAD_W], {tla_pkg::PAD_W{1'b0}}};

   // only mode and polarity bits are host writable; flag bits are read-only
   assign cfg_wr_word = i_wr_data & tla_pkg::CFG_WR_MASK;

   // writable limits per channel
   // write strobe decode, one selector value per register
   assign wr_cfg      = i_wr_en && (i_wr_sel == tla_pkg::SEL_CFG);
   assign wr_high[0]  = i_wr_en && (i_wr_sel == tla_pkg::SEL_HIGH1);
   assign wr_low[0]   = i_wr_en && (i_wr_sel == tla_pkg::SEL_LOW1);
   assign wr_high[1]  = i_wr_en && (i_wr_sel == tla_pkg::SEL_HIGH2);
   assign wr_low[1]   = i_wr_en && (i_wr_sel == tla_pkg::SEL_LOW2);

   // per-channel clear bytes
   // other command bytes are ignored here; the link layer handles them
   assign alert_clr[0] = i_cmd_valid && (i_cmd_byte == tla_pkg::CMD_ALERT_CLR1);
   assign alert_clr[1] = i_cmd_valid && (i_cmd_byte == tla_pkg::CMD_ALERT_CLR2);

   // per-channel mode select bit
   // 0 selects the latched window, 1 the threshold detector
   assign therm_mode[0] = cfg_reg[tla_pkg::CFG_MODE1_BIT];
   assign therm_mode[1] = cfg_reg[tla_pkg::CFG_MODE2_BIT];

   assign polarity[0]   = cfg_reg[tla_pkg::CFG_CHANNEL_ONE_POLARITY_BIT];
   assign polarity[1]   = cfg_reg[tla_pkg::CFG_CHANNEL_TWO_POLARITY_BIT];

   // register holds last result
   // a software reset wins over a conversion landing in the same cycle
   assign temp_next = i_soft_reset ? tla_pkg::TEMP_RST :
                      i_conv_done  ? conv_word :
                                     temp_reg;

   // read sees flags before clear
   // channels in window mode clear their flags on the edge that takes the read strobe,
   // so the word is built from the flag flops as they stand before that edge
   always_comb begin
      rd_word                         = cfg_reg & tla_pkg::CFG_WR_MASK;
      rd_word[tla_pkg::CFG_FH1_BIT]   = ch_flags[0].high_excursion_flag;
      rd_word[tla_pkg::CFG_FL1_BIT]   = ch_flags[0].low_excursion_flag;
      rd_word[tla_pkg::CFG_FH2_BIT]   = ch_flags[1].high_excursion_flag;
      rd_word[tla_pkg::CFG_FL2_BIT]   = ch_flags[1].low_excursion_flag;
   end

   // read capture holds its value until the next read
   assign rdata_next = i_cfg_rd ? rd_word : rdata_reg;

   // load limits after reset
   // limits, load sequencer and configuration next state
   always_comb begin
      ld_next     = ld_reg;
      lim_next    = lim_reg;
      loaded_next = loaded_reg;
      cfg_next    = cfg_reg;
      case (ld_reg)
         // waiting for the store; host limit writes are dropped meanwhile,
         // since the load would overwrite them once the store is settled anyway
         LD_PEND: begin
            if (i_nvm_valid) begin
               lim_next    = i_nvm_lim;
               loaded_next = 1'b1;
               ld_next     = LD_DONE;
            end
         end
         // defaults in place; host writes replace them
         LD_DONE: begin
            if (wr_high[0]) begin
               lim_next[0].high = wr_word;
            end
            if (wr_low[0]) begin
               lim_next[0].low = wr_word;
            end
            if (wr_high[1]) begin
               lim_next[1].high = wr_word;
            end
            if (wr_low[1]) begin
               lim_next[1].low = wr_word;
            end
         end
         // unreachable encoding: start the load over
         default: begin
            ld_next = LD_PEND;
         end
      endcase
      // configuration writes are taken at any time
      if (wr_cfg) begin
         cfg_next = cfg_wr_word;
      end
      // software reset reloads defaults
      // a software reset restarts the load and returns the configuration
      if (i_soft_reset) begin
         ld_next     = LD_PEND;
         loaded_next = 1'b0;
         cfg_next    = tla_pkg::CFG_RST;
      end
   end

   // sequencer, limit and configuration flops
   // limits reset to the disabling codes so that no alert trips before the load
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ld_reg            <= LD_PEND;
         lim_reg[0].high   <= tla_pkg::LIM_HIGH_OFF;
         lim_reg[0].low    <= tla_pkg::LIM_LOW_OFF;
         lim_reg[1].high   <= tla_pkg::LIM_HIGH_OFF;
         lim_reg[1].low    <= tla_pkg::LIM_LOW_OFF;
         loaded_reg        <= 1'b0;
         cfg_reg           <= tla_pkg::CFG_RST;
      end else begin
         ld_reg            <= ld_next;
         lim_reg           <= lim_next;
         loaded_reg        <= loaded_next;
         cfg_reg           <= cfg_next;
      end
   end

   // temperature register flop
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         temp_reg <= tla_pkg::TEMP_RST;
      end else begin
         temp_reg <= temp_next;
      end
   end

   // read capture and its one-cycle valid strobe
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_reg  <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= i_cfg_rd;
      end
   end

   // both channels see each result
   // one channel instance per alert pin; the channel compares the word of
   // the cycle in which the conversion strobe stands, not the older register
   // limitation: a software reset does not clear channel flags or outputs,
   // they follow the next conversion or release command instead
   genvar ch;
   generate
      for (ch = 0; ch < N_CH; ch++) begin : g_chan
         tla_channel u_tla_channel (
            .i_clk        (i_clk),
            .i_rstn       (i_rstn),
            .i_conv_done  (i_conv_done),
            .i_temp_word  (conv_word),
            .i_lim        (lim_reg[ch]),
            .i_therm_mode (therm_mode[ch]),
            .i_polarity   (polarity[ch]),
            .i_cfg_rd     (i_cfg_rd),
            .i_alert_clr  (alert_clr[ch]),
            .o_flags      (ch_flags[ch]),
            .o_pin_o      (pin_o[ch]),
            .o_pin_oe     (pin_oe[ch])
         );
      end
   endgenerate

   // outputs, each taken straight from a flop
   assign o_temp_word          = temp_reg;
   assign o_lim                = lim_reg;
   assign o_cfg_ctrl           = cfg_reg;
   assign o_cfg_rdata          = rdata_reg;
   assign o_cfg_rvalid         = rvalid_reg;
   assign o_flags              = ch_flags;
   assign o_lim_loaded         = loaded_reg;

   // open-drain pins only
   // data is always low; only the enable moves
   assign o_limit_output_n_o   = pin_o;
   assign o_limit_output_n_oe  = pin_oe;

endmodule : tla_alert_top

// [tla_alert_top_tb.sv]
// self-checking bench: strobes, conversions and resolved alert lines
// assumes outputs settle within three cycles of a strobe
`timescale 1ns/1ps
module tla_alert_top_tb;
   logic i_clk = 1'b0, i_rstn = 1'b0, i_conv_done = 1'b0, i_wr_en = 1'b0, i_cfg_rd = 1'b0, i_cmd_valid = 1'b0;
   logic [13:0] i_conv_code = 14'h0000;
   logic [15:0] i_wr_data = 16'h0000, o_temp_word, o_cfg_ctrl, o_cfg_rdata, d;
   logic [7:0] i_cmd_byte = 8'h00;
   logic [1:0] pin_o, pin_oe, line;
   logic o_cfg_rvalid, ll, i_soft_reset = 1'b0;
   tla_pkg::tla_sel_t i_wr_sel = tla_pkg::SEL_NONE;
   tla_pkg::tla_lim_t [1:0] i_nvm_lim = 64'h3200_F000_3200_F000, o_lim;  // 50 and -16 degrees
   tla_pkg::tla_flags_t [1:0] o_flags;
   int n_mismatch = 0, checked = 0;
   tla_alert_top u_tla_alert_top (.i_clk, .i_rstn, .i_conv_done, .i_conv_code, .i_nvm_lim, .i_nvm_valid(1'b1),
      .i_soft_reset, .i_wr_en, .i_wr_sel, .i_wr_data, .i_cfg_rd, .i_cmd_valid, .i_cmd_byte, .o_temp_word,
      .o_lim, .o_cfg_ctrl, .o_cfg_rdata, .o_cfg_rvalid, .o_flags, .o_lim_loaded(ll), .o_limit_output_n_o(pin_o),
      .o_limit_output_n_oe(pin_oe));
   tla_host_model u_tla_host_model (.i_pull_o(pin_o), .i_pull_oe(pin_oe), .o_line(line));
   initial forever #4 i_clk = ~i_clk;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one-cycle strobe, k: 0 conversion (v is the word), 1 write, 2 command, 3 configuration read, 4 soft reset
   task automatic req(input int k, input logic [2:0] s, input logic [15:0] v);
      @(posedge i_clk);
      i_conv_code <= v[15:2];
      i_wr_sel <= tla_pkg::tla_sel_t'(s);
      i_wr_data <= v;
      i_cmd_byte <= v[7:0];
      {i_conv_done, i_wr_en, i_cmd_valid, i_cfg_rd} <= {k == 0, k == 1, k == 2, k == 3};
      i_soft_reset <= (k == 4);
      @(posedge i_clk);
      {i_conv_done, i_wr_en, i_cmd_valid, i_cfg_rd} <= 4'h0;
      i_soft_reset <= 1'b0;
      d = 16'hFFFF;
      // settled values are sampled mid-cycle
      repeat (4) begin
         @(negedge i_clk);
         if (o_cfg_rvalid === 1'b1) d = o_cfg_rdata;
      end
   endtask : req
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // watchdog, run needs about 64 cycles
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (3) @(negedge i_clk);
      chk("high1 default", 16'h3200, o_lim[0].high);
      chk("loaded", 16'h0001, 16'(ll));
      req(1, tla_pkg::SEL_CFG, 16'h0200);
      req(0, 3'd0, 16'h5020);
      chk("temp", 16'h5020, o_temp_word);
      chk("flags hot", 16'h000A, 16'(o_flags));
      chk("pins hot", 16'h0000, 16'(line));
      req(3, 3'd0, 16'h0000);
      chk("read flags", 16'h000A, 16'(d[15:12]));
      chk("flags read", 16'h0008, 16'(o_flags));
      chk("pins read", 16'h0001, 16'(line));
      $display("hot done");
      req(0, 3'd0, 16'hC900);
      chk("flags cold", 16'h0001, 16'(o_flags));
      chk("pins cold", 16'h0002, 16'(line));
      req(2, 3'd0, 16'h00B5);
      req(2, 3'd0, 16'h0075);
      chk("flags clear", 16'h0001, 16'(o_flags));
      chk("pins clear", 16'h0003, 16'(line));
      $display("cold done");
      req(3, 3'd0, 16'h0000);
      req(1, tla_pkg::SEL_HIGH1, 16'h7FFC);
      req(1, tla_pkg::SEL_LOW1, 16'h8000);
      req(1, tla_pkg::SEL_CFG, 16'h0280);
      req(0, 3'd0, 16'h5020);
      chk("flags off", 16'h0008, 16'(o_flags));
      chk("pins off", 16'h0000, 16'(line));
      chk("high1 written", 16'h7FFC, o_lim[0].high);
      chk("cfg written", 16'h0280, o_cfg_ctrl);
      $display("disable done");
      req(4, 3'd0, 16'h0000);
      chk("high1 reloaded", 16'h3200, o_lim[0].high);
      chk("cfg reset", 16'h0000, o_cfg_ctrl);
      chk("reloaded", 16'h0001, 16'(ll));
      $display("reload done");
      finish_test();
   end
endmodule : tla_alert_top_tb

// [tla_channel.sv]
// one alert channel: compare, flag latching or hysteresis, open-drain output
// assumes conversion pulses and host strobes are one cycle wide on i_clk
`timescale 1ns/1ps
module tla_channel (
   input  wire logic              i_clk,          // device clock
   input  wire logic              i_rstn,         // async reset, active low
   input  wire logic              i_conv_done,    // new result present this cycle
   input  wire logic [15:0]       i_temp_word,    // new left-justified result
   input  wire tla_pkg::tla_lim_t i_lim,          // this channel's limits
   input  wire logic              i_therm_mode,   // 1 = threshold, 0 = latched window
   input  wire logic              i_polarity,     // active level of the output
   input  wire logic              i_cfg_rd,       // configuration read strobe
   input  wire logic              i_alert_clr,    // global alert clear for this channel
   output tla_pkg::tla_flags_t    o_flags,        // excursion flags
   output logic                   o_pin_o,        // open-drain data, always low
   output logic                   o_pin_oe        // high while pulling the line low
);

   logic              fh_reg;        // high excursion flag
   logic              fh_next;
   logic              fl_reg;        // low excursion flag
   logic              fl_next;
   logic              act_reg;       // channel output asserted
   logic              act_next;
   logic              oe_reg;        // pin pull-down enable
   logic              level_next;    // wanted line level
   wire  logic        above;         // result above the high limit
   wire  logic        below;         // result below the low limit
   wire  logic        rd_or_clr;     // release of a latched output

   assign above     = i_conv_done && ($signed(i_temp_word) > $signed(i_lim.high));
   assign below     = i_conv_done && ($signed(i_temp_word) < $signed(i_lim.low));
   assign rd_or_clr = i_cfg_rd | i_alert_clr;

   // next flag and output state; a new excursion wins over a clear in the same cycle
   always_comb begin
      fh_next  = fh_reg;
      fl_next  = fl_reg;
      act_next = act_reg;
      if (i_therm_mode) begin
         if (above) begin
            fh_next = 1'b1;
         end else if (below) begin
            fh_next = 1'b0;
         end
         fl_next  = 1'b0;
         act_next = fh_next;
      end else begin
         fh_next  = above | (fh_reg & ~i_cfg_rd);
         fl_next  = below | (fl_reg & ~i_cfg_rd);
         act_next = above | below | (act_reg & ~rd_or_clr);
      end
   end

   assign level_next = act_next ? i_polarity : ~i_polarity;

   // state flops; the pin enable is registered so the output is glitch free
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fh_reg  <= 1'b0;
         fl_reg  <= 1'b0;
         act_reg <= 1'b0;
         // released in reset: idle level with the reset polarity is high
         oe_reg  <= 1'b0;
      end else begin
         fh_reg  <= fh_next;
         fl_reg  <= fl_next;
         act_reg <= act_next;
         oe_reg  <= ~level_next;
      end
   end

   // data side of the open-drain pin never drives high
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pin_o <= 1'b0;
      end else begin
         o_pin_o <= 1'b0;
      end
   end

   assign o_flags.high_excursion_flag = fh_reg;
   assign o_flags.low_excursion_flag  = fl_reg;
   assign o_pin_oe                    = oe_reg;

endmodule : tla_channel

// [tla_host_model.sv]
// host side of the two alert lines, each with a pull-up
// assumes the device only drives while its enable is high
`timescale 1ns/1ps
module tla_host_model (
   input  wire logic [1:0] i_pull_o,   // device pin data
   input  wire logic [1:0] i_pull_oe,  // device pin enables
   output logic      [1:0] o_line      // resolved line levels
);
   assign o_line = {i_pull_oe[1] ? i_pull_o[1] : 1'b1, i_pull_oe[0] ? i_pull_o[0] : 1'b1};
endmodule : tla_host_model

// [tla_pkg.sv]
// constants, field layouts and carrier types of the temperature limit and alert logic
// assumes one 125 mhz clock shared with the link layer and the conversion engine
package tla_pkg;

   // register word layout: 14-bit code, left-justified in 16 bits
   localparam int unsigned WORD_W = 16;               // width of every register word
   localparam int unsigned CODE_W = 14;               // width of the temperature code
   localparam int unsigned PAD_W  = WORD_W - CODE_W;  // zero bits below the code

   // clock rate, kept for timing derivations elsewhere
   localparam int unsigned CLK_PERIOD_NS = 8;

   // reset value of the temperature register
   localparam logic [15:0] TEMP_RST = 16'h0000;

   // limit values that switch alerting off (highest and lowest code)
   localparam logic [15:0] LIM_HIGH_OFF = 16'h7FFC;
   localparam logic [15:0] LIM_LOW_OFF  = 16'h8000;

   // configuration word bit positions
   localparam int unsigned CFG_CHANNEL_ONE_POLARITY_BIT  = 7;   // channel one output polarity
   localparam int unsigned CFG_CHANNEL_TWO_POLARITY_BIT  = 3;   // channel two output polarity
   localparam int unsigned CFG_MODE1_BIT = 10;  // channel one latch or threshold select
   localparam int unsigned CFG_MODE2_BIT = 9;   // channel two latch or threshold select
   localparam int unsigned CFG_FH1_BIT   = 15;  // channel one high excursion flag
   localparam int unsigned CFG_FL1_BIT   = 14;  // channel one low excursion flag
   localparam int unsigned CFG_FH2_BIT   = 13;  // channel two high excursion flag
   localparam int unsigned CFG_FL2_BIT   = 12;  // channel two low excursion flag

   // host-writable bits of the configuration word, and its reset value
   localparam logic [15:0] CFG_WR_MASK = 16'h0688;
   localparam logic [15:0] CFG_RST     = 16'h0000;

   // global alert clear command bytes
   localparam logic [7:0] CMD_ALERT_CLR1 = 8'hB5;
   localparam logic [7:0] CMD_ALERT_CLR2 = 8'h75;

   // register selector used by the link layer for writes
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_CFG,
      SEL_HIGH1,
      SEL_LOW1,
      SEL_HIGH2,
      SEL_LOW2
   } tla_sel_t;

   // pair of limit words of one channel
   typedef struct packed {
      logic [15:0] high;
      logic [15:0] low;
   } tla_lim_t;

   // excursion flags of one channel
   typedef struct packed {
      logic high_excursion_flag;
      logic low_excursion_flag;
   } tla_flags_t;

endpackage : tla_pkg
